// File: rtl/pmeif_consts.vh
// Purpose: Constants of the event flag and interrupt block
// Assumes: 32-bit AHB-Lite words, register index times four is the address
// Notes: Definitions only
`ifndef PMEIF_CONSTS_VH
`define PMEIF_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PMEIF_IDX_STATUS_A 8'h39
`define PMEIF_IDX_MASK_A 8'h3A
`define PMEIF_IDX_STATUS_B 8'h3B
`define PMEIF_IDX_CLEAR_A 8'h41
`define PMEIF_IDX_CLEAR_B 8'h42
`define PMEIF_IDX_ENABLE_B 8'h43
`define PMEIF_IDX_MON_SEL 8'h44

// ****************************************************************
// Reset values
// ****************************************************************
`define PMEIF_RST_STATUS_A 8'h00
`define PMEIF_RST_STATUS_B 8'h00
`define PMEIF_RST_MASK_A 8'hFF
`define PMEIF_RST_ENABLE_B 8'h00
`define PMEIF_RST_MON_SEL 2'h0

// ****************************************************************
// Field positions of event_status_a and event_mask_a
// ****************************************************************
`define PMEIF_BIT_PIN1_FALL 7
`define PMEIF_BIT_PIN1_RISE 6
`define PMEIF_BIT_THERMAL_WARN 5
`define PMEIF_BIT_HOLD_RISE 4
`define PMEIF_BIT_BUTTON_LONG 3
`define PMEIF_BIT_BUTTON_EVENT 2
`define PMEIF_BIT_VOLT_MONITOR 1
`define PMEIF_BIT_HOLD_FALL 0

// ****************************************************************
// Sampled pin vector layout
// ****************************************************************
`define PMEIF_PIN_COUNT 8
`define PMEIF_PIN_GPIO_LO 0
`define PMEIF_PIN_HOLD 5
`define PMEIF_PIN_BUTTON_N 6
`define PMEIF_PIN_VOLT_LOW 7

// ****************************************************************
// Timing
// ****************************************************************
`define PMEIF_ARM_CYCLES 2'h3

`endif

// File: rtl/pmeif_top.v
// Purpose: Event flags, mask and interrupt request of a power device
// Assumes: AHB-Lite slave, single word transfers, one clock hclk
// Notes: Pins pass a two-stage synchroniser before edge detection
`timescale 1ns/1ps
`include "pmeif_consts.vh"

module pmeif_top #(
  parameter GPIO_COUNT = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire pin1_input,
  input wire [GPIO_COUNT-1:0] pin_group_input,
  input wire power_hold_input,
  input wire power_button_input_n,
  input wire monitored_voltage_input,
  input wire thermal_warn_event,
  input wire button_long_event,
  output reg [1:0] monitor_threshold_select,
  output reg irq
);

  // ****************************************************************
  // Synchronisers and edge detectors
  // ****************************************************************
  wire [`PMEIF_PIN_COUNT-1:0] pin_raw;
  reg [`PMEIF_PIN_COUNT-1:0] pin_meta;
  reg [`PMEIF_PIN_COUNT-1:0] pin_sync;
  reg [`PMEIF_PIN_COUNT-1:0] pin_prev;
  reg [1:0] arm_count;
  wire armed;
  wire [`PMEIF_PIN_COUNT-1:0] pin_rise;
  wire [`PMEIF_PIN_COUNT-1:0] pin_fall;

  // Bits 0..3: pins 2..5, bit 4: pin 1
  assign pin_raw = {monitored_voltage_input, power_button_input_n,
                    power_hold_input, pin1_input, pin_group_input};
  assign armed = (arm_count == `PMEIF_ARM_CYCLES);

  genvar gi;
  generate
    for (gi = 0; gi < `PMEIF_PIN_COUNT; gi = gi + 1) begin : g_pin
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
      // Edges ignored until the pipeline holds real pin levels
      assign pin_rise[gi] = armed & pin_sync[gi] & ~pin_prev[gi];
      assign pin_fall[gi] = armed & ~pin_sync[gi] & pin_prev[gi];
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_count <= 2'h0;
    end else if (!armed) begin
      arm_count <= arm_count + 2'h1;
    end
  end

  // ****************************************************************
  // Event set vectors
  // ****************************************************************
  reg [7:0] set_a;
  reg [7:0] set_b;
  integer k;

  always @* begin
    set_a = 8'h00;
    set_a[`PMEIF_BIT_PIN1_FALL] = pin_fall[4];
    set_a[`PMEIF_BIT_PIN1_RISE] = pin_rise[4];
    set_a[`PMEIF_BIT_THERMAL_WARN] = thermal_warn_event;
    set_a[`PMEIF_BIT_HOLD_RISE] = pin_rise[`PMEIF_PIN_HOLD];
    set_a[`PMEIF_BIT_BUTTON_LONG] = button_long_event;
    // Button pressed when the active-low input falls
    set_a[`PMEIF_BIT_BUTTON_EVENT] = pin_fall[`PMEIF_PIN_BUTTON_N];
    // Comparator output high means below threshold, no filtering
    set_a[`PMEIF_BIT_VOLT_MONITOR] = pin_rise[`PMEIF_PIN_VOLT_LOW];
    set_a[`PMEIF_BIT_HOLD_FALL] = pin_fall[`PMEIF_PIN_HOLD];
    set_b = 8'h00;
    for (k = 0; k < GPIO_COUNT; k = k + 1) begin
      set_b[2*k] = pin_rise[k];
      set_b[2*k+1] = pin_fall[k];
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  reg wr_pend;
  reg [7:0] wr_idx;
  wire take;
  wire [7:0] addr_idx;

  assign take = hsel & htrans[1] & hready;
  assign addr_idx = haddr[9:2];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take & hwrite;
      if (take) begin
        wr_idx <= addr_idx;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  wire [7:0] wbyte;
  wire wr_status_a;
  wire wr_status_b;
  wire wr_clear_a;
  wire wr_clear_b;
  assign wbyte = hwdata[7:0];
  assign wr_status_a = wr_pend & (wr_idx == `PMEIF_IDX_STATUS_A);
  assign wr_status_b = wr_pend & (wr_idx == `PMEIF_IDX_STATUS_B);
  assign wr_clear_a = wr_pend & (wr_idx == `PMEIF_IDX_CLEAR_A);
  assign wr_clear_b = wr_pend & (wr_idx == `PMEIF_IDX_CLEAR_B);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] event_status_a;
  reg [7:0] event_status_b;
  reg [7:0] event_mask_a;
  reg [7:0] event_enable_b;
  wire [7:0] clr_a;
  wire [7:0] clr_b;
  wire [7:0] next_status_a;
  wire [7:0] next_status_b;

  // Only bits written as one acknowledge; a new event beats the clear
  assign clr_a = (wr_status_a | wr_clear_a) ? wbyte : 8'h00;
  assign clr_b = (wr_status_b | wr_clear_b) ? wbyte : 8'h00;
  assign next_status_a = (event_status_a & ~clr_a) | set_a;
  assign next_status_b = (event_status_b & ~clr_b) | set_b;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_status_a <= `PMEIF_RST_STATUS_A;
      event_status_b <= `PMEIF_RST_STATUS_B;
      event_mask_a <= `PMEIF_RST_MASK_A;
      event_enable_b <= `PMEIF_RST_ENABLE_B;
      monitor_threshold_select <= `PMEIF_RST_MON_SEL;
    end else begin
      event_status_a <= next_status_a;
      event_status_b <= next_status_b;
      if (wr_pend && wr_idx == `PMEIF_IDX_MASK_A) begin
        event_mask_a <= wbyte;
      end
      if (wr_pend && wr_idx == `PMEIF_IDX_ENABLE_B) begin
        event_enable_b <= wbyte;
      end
      if (wr_pend && wr_idx == `PMEIF_IDX_MON_SEL) begin
        monitor_threshold_select <= hwdata[1:0];
      end
    end
  end

  // ****************************************************************
  // Read data and interrupt
  // ****************************************************************
  reg [7:0] rd_byte;
  always @* begin
    case (addr_idx)
      `PMEIF_IDX_STATUS_A: rd_byte = next_status_a;
      `PMEIF_IDX_MASK_A: rd_byte = event_mask_a;
      `PMEIF_IDX_STATUS_B: rd_byte = next_status_b;
      `PMEIF_IDX_ENABLE_B: rd_byte = event_enable_b;
      `PMEIF_IDX_MON_SEL: rd_byte = {6'h00, monitor_threshold_select};
      default: rd_byte = 8'h00;
    endcase
  end

  wire [7:0] next_mask_a;
  wire [7:0] next_enable_b;
  assign next_mask_a = (wr_pend && wr_idx == `PMEIF_IDX_MASK_A) ?
                       wbyte : event_mask_a;
  assign next_enable_b = (wr_pend && wr_idx == `PMEIF_IDX_ENABLE_B) ?
                         wbyte : event_enable_b;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      if (take && !hwrite) begin
        hrdata <= {24'h000000, rd_byte};
      end
      // Mask bit one blocks its flag, same bit position
      irq <= (|(next_status_a & ~next_mask_a)) |
             (|(next_status_b & next_enable_b));
    end
  end

endmodule // pmeif_top

// File: verification/pmeif_top_assertions.sv
// Purpose: Port checks of pmeif_top
// Assumes: One slave, hready equals hreadyout
// Notes: Bound into every pmeif_top
`timescale 1ns/1ps
module pmeif_checker (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic thermal_warn_event,
  input logic button_long_event,
  input logic [1:0] monitor_threshold_select,
  input logic irq
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wrote;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wrote <= 1'h0;
    else if (hsel && htrans[1] && hready && hwrite) wrote <= 1'h1;
  end
  sequence take(bit w, bit [7:0] x);
    hsel && htrans[1] && hready && hwrite == w && haddr[9:2] == x;
  endsequence
  AST_MASK_RST: assert property (!wrote |-> !irq)
    else $error("irq raised while every event is masked");
  AST_SEL_RST: assert property (!wrote |->
    monitor_threshold_select == 2'h0) else $error("select not reset");
  AST_THERM: assert property (take(1'h0, 8'h39)
    ##0 thermal_warn_event |=> hrdata[5]) else $error("thermal flag lost");
  AST_LONG: assert property (take(1'h0, 8'h39)
    ##0 button_long_event |=> hrdata[3]) else $error("long press lost");
  AST_SEL_WR: assert property (take(1'h1, 8'h44) ##1 1'h1 |=>
    monitor_threshold_select == $past(hwdata[1:0])) else $error("sel");
  AST_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite)
    |=> $stable(hrdata)) else $error("read data changed without read");
  AST_HI_ZERO: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
endmodule // pmeif_checker
bind pmeif_top pmeif_checker pmeif_checker_i (.*);

// File: verification/tb_pmeif_top.sv
// Purpose: Self-checking bench of pmeif_top
// Assumes: hready fed back from hreadyout
// Notes: Read data scored from a queue of expected bytes
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_pmeif_top;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic pin1_input = 1'h0, power_hold_input = 1'h0;
  logic power_button_input_n = 1'h1, monitored_voltage_input = 1'h0;
  logic thermal_warn_event = 1'h0, button_long_event = 1'h0;
  logic hreadyout, hresp, irq, rd_pend = 1'h0;
  logic [1:0] htrans = 2'h0, monitor_threshold_select;
  logic [2:0] hsize = 3'h2;
  logic [3:0] pin_group_input = 4'h0;
  logic [7:0] q[$], e, r;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  wire hready = hreadyout;
  int errors = 0, num_checks = 0, cyc = 0, seed = 32'h4DA9;
  pmeif_top pmeif_top_i (.*);
  initial forever #5 hclk = ~hclk;
  task automatic results(int extra);
    errors += extra;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) results(1);
    if (rd_pend) begin
      e = q.pop_front();
      `CHK("hrdata", e, hrdata[7:0])
    end
    rd_pend <= hsel && htrans[1] && hready && !hwrite;
  end
  task automatic idle(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer(logic w, logic [7:0] i, logic [7:0] d);
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (!hready);
  endtask
  task automatic rd(logic [7:0] i, logic [7:0] x);
    q.push_back(x);
    xfer(1'h0, i, 8'h0);
  endtask
  task automatic chk_irq(logic x);
    @(negedge hclk);
    `CHK("irq", x, irq)
    @(posedge hclk);
  endtask
  task automatic ev;
    thermal_warn_event <= 1'h1;
    button_long_event <= 1'h1;
    @(posedge hclk);
    thermal_warn_event <= 1'h0;
    button_long_event <= 1'h0;
  endtask
  task automatic pins(logic v);
    pin1_input <= v;
    power_hold_input <= v;
    monitored_voltage_input <= v;
    power_button_input_n <= !v;
    pin_group_input <= {4{v}};
    idle(5);
  endtask
  task automatic rst_chk;
    hresetn <= 1'h0;
    idle(3);
    hresetn <= 1'h1;
    idle(1);
    rd(8'h39, 8'h0);
    rd(8'h3A, 8'hFF);
    rd(8'h3B, 8'h0);
    chk_irq(1'h0);
    `CHK("sel", 2'h0, monitor_threshold_select)
  endtask
  initial begin
    rst_chk();
    rd(8'h07, 8'h0);
    pins(1'h1);
    rd(8'h39, 8'h56);
    rd(8'h3B, 8'h55);
    pins(1'h0);
    rd(8'h39, 8'hD7);
    rd(8'h3B, 8'hFF);
    fork
      ev();
      rd(8'h39, 8'hFF);
    join
    r = 8'($random(seed));
    xfer(1'h1, 8'h39, r);
    rd(8'h39, ~r);
    xfer(1'h1, 8'h41, ~r);
    rd(8'h39, 8'h0);
    ev();
    chk_irq(1'h0);
    for (int i = 0; i < 8; i++) begin
      xfer(1'h1, 8'h3A, ~(8'h1 << i));
      chk_irq(i == 3 || i == 5);
    end
    r = 8'($random(seed));
    xfer(1'h1, 8'h3A, r);
    rd(8'h3A, r);
    chk_irq(!(r[5] && r[3]));
    xfer(1'h1, 8'h3A, 8'h0);
    xfer(1'h1, 8'h39, 8'h20);
    chk_irq(1'h1);
    xfer(1'h1, 8'h41, 8'h08);
    chk_irq(1'h0);
    xfer(1'h1, 8'h43, 8'hFF);
    chk_irq(1'h1);
    xfer(1'h1, 8'h42, 8'hFF);
    rd(8'h3B, 8'h0);
    chk_irq(1'h0);
    r = 8'($random(seed));
    xfer(1'h1, 8'h44, r);
    rd(8'h44, r & 8'h3);
    `CHK("sel", r[1:0], monitor_threshold_select)
    ev();
    rst_chk();
    idle(2);
    results(0);
  end
endmodule // tb_pmeif_top
